// ---- hw/sbc_map.svh ----
/*
 Constants for the clear / write-nvm command handler: command codes,
 field positions, reset values and timing counts.
 Assumes inclusion by bare name from the package and the design.
*/
`ifndef SBC_MAP_SVH
`define SBC_MAP_SVH
// Command codes
`define SBC_CMD_CLEAR 4'h7
`define SBC_CMD_UNUSED8 4'h8
`define SBC_CMD_WRITE_NVM 4'h9
// Global device address
`define SBC_GLOBAL_ADDR 4'h0
// Data field positions
`define SBC_WA_HI 7
`define SBC_WA_LO 4
`define SBC_RD_HI 3
`define SBC_RD_LO 0
// Nibble index of the device address in the mirror array
`define SBC_ADDR_NIBBLE 4'h0
// Reset values
`define SBC_ADDR_RST 4'h0
`define SBC_RESP_RST 16'h0000
// Timing: bus switch open time (ns) and cycles at 10 ns
`define SBC_CLK_NS 10
`define SBC_BSOPEN_NS 1000
`define SBC_BSOPEN_CYC ((`SBC_BSOPEN_NS) / (`SBC_CLK_NS))
// Per-bit programming time (ns) and cycles
`define SBC_PROG_BIT_NS 2000
`define SBC_PROG_BIT_CYC ((`SBC_PROG_BIT_NS) / (`SBC_CLK_NS))
`endif

// ---- hw/sbc_pkg.sv ----
/*
 Types for the clear / write-nvm command handler.
 Assumes sbc_map.svh is on the include path.
*/
`include "sbc_map.svh"
package sbc_pkg;
   typedef enum logic [1:0] {SBC_FMT_STD_LONG, SBC_FMT_STD_SHORT, SBC_FMT_ENH_LONG,
      SBC_FMT_ENH_SHORT} sbc_fmt_t;
   typedef enum logic [1:0] {SBC_IDLE, SBC_PROG, SBC_CLEAR} sbc_state_t;
endpackage : sbc_pkg

// ---- hw/sbc_cmd.sv ----
/*
 Clear and write-nvm command execution for the sensor bus decoder.
 Assumes a frame decoder upstream delivers one-cycle frame_valid with
 code, address, data, format and a crc_ok flag, all synchronous to clk.
*/
// Behaviour
// [RULE1] Clear accepted in all four command formats.
// [RULE2] Code 0111 is clear; needs good frame and own or global address.
// [RULE3] Accepted clear opens bus switch in time and resets the logic.
// [RULE4] Clear data bits carry no meaning beyond the crc check.
// [RULE5] Clear never produces a response frame.
// [RULE6] Clear with foreign address is ignored.
// [RULE7] Code 1000 is ignored in every format.
// [RULE8] Write nvm only in long formats; short ones ignored.
// [RULE9] Write nvm ignored while own address is still global.
// [RULE10] Code 1001 decodes as write nvm.
// [RULE11] Upper data nibble is nibble address, lower nibble is data.
// [RULE12] Write nvm needs exact own address; global does not count.
// [RULE13] With programming enabled, data goes into the addressed otp nibble.
// [RULE14] Enabled response: address, nibble address, 11, bank, read-back.
// [RULE15] Disabled: mirror updated; response address, 0000, 1111, address.
// [RULE16] Response bank bits equal bank from last initialization.
// [RULE17] Master spaces frames for per-bit program time times bit count.
// [RULE18] Frames failing crc are discarded without action or response.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_map.svh"
module sbc_cmd
   import sbc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Decoded frame
   input wire logic frame_valid,
   input wire logic crc_ok,
   input wire logic [3:0] cmd_code,
   input wire logic [3:0] cmd_addr,
   input wire logic [7:0] cmd_data,
   input wire sbc_fmt_t cmd_fmt,
   // Configuration from initialization
   input wire logic otp_program_enable,
   input wire logic [1:0] bank_select,
   input wire logic init_addr_load,
   input wire logic [3:0] init_addr,
   // Response path
   output logic resp_valid,
   output logic [15:0] resp_data,
   // Otp programming strobe
   output logic otp_wr,
   output logic [3:0] otp_wr_addr,
   output logic [3:0] otp_wr_data,
   // Clear effects
   output logic bus_switch_open,
   output logic logic_reset,
   output logic busy,
   // Current device address
   output logic [3:0] assigned_device_address
);

   // ********************************************************
   // Decode
   // ********************************************************
   localparam logic [15:0] BSOPEN_CYC = 16'(`SBC_BSOPEN_CYC);
   localparam logic [15:0] PROG_CYC = 16'(`SBC_PROG_BIT_CYC);

   // Count of ones in a nibble, used for program duration
   function automatic logic [2:0] ones4(input logic [3:0] n);
      ones4 = 3'(n[0]) + 3'(n[1]) + 3'(n[2]) + 3'(n[3]);
   endfunction : ones4

   logic [3:0] mirror_q [16];
   logic [3:0] mirror_d [16];
   sbc_state_t state_q;
   sbc_state_t state_d;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic [3:0] addr_q;
   logic resp_valid_q;
   logic [15:0] resp_q;
   logic otp_wr_q;
   logic [3:0] otp_a_q;
   logic [3:0] otp_dat_q;
   logic bsw_q;
   logic lrst_q;
   logic busy_q;

   wire logic [3:0] wa = cmd_data[`SBC_WA_HI:`SBC_WA_LO]; // [RULE11]
   wire logic [3:0] rd = cmd_data[`SBC_RD_HI:`SBC_RD_LO]; // [RULE11]
   wire logic good = frame_valid && crc_ok && (state_q == SBC_IDLE); // [RULE18]
   wire logic is_long = (cmd_fmt == SBC_FMT_STD_LONG) || (cmd_fmt == SBC_FMT_ENH_LONG);
   // Any format takes clear; data bits are not looked at
   wire logic clr_hit = good && (cmd_code == `SBC_CMD_CLEAR)
      && ((cmd_addr == addr_q) || (cmd_addr == `SBC_GLOBAL_ADDR)); // [RULE1] [RULE2] [RULE4] [RULE6]
   // Code 1000 matches neither decode, so it falls through untouched
   wire logic wr_hit = good && (cmd_code == `SBC_CMD_WRITE_NVM) && is_long
      && (addr_q != `SBC_GLOBAL_ADDR) && (cmd_addr == addr_q); // [RULE7] [RULE8] [RULE9] [RULE10] [RULE12]
   wire logic wr_otp = wr_hit && otp_program_enable; // [RULE13]
   wire logic wr_mir = wr_hit && !otp_program_enable; // [RULE15]
   wire logic [3:0] new_addr = (wr_mir && (wa == `SBC_ADDR_NIBBLE)) ? rd : addr_q;
   wire logic [15:0] resp_otp = {addr_q, wa, 2'b11, bank_select, rd}; // [RULE14] [RULE16]
   wire logic [15:0] resp_mir = {new_addr, 4'h0, 4'hf, new_addr}; // [RULE15]

   // ********************************************************
   // Next state
   // ********************************************************
   // Program time scales with programmed bits so the master can space frames
   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      for (int i = 0; i < 16; i++)
      begin
         mirror_d[i] = mirror_q[i];
      end
      // Initialization assigns the address; without it writes stay locked out
      if (init_addr_load)
      begin
         mirror_d[`SBC_ADDR_NIBBLE] = init_addr;
      end
      unique case (state_q)
         SBC_IDLE:
         begin
            if (clr_hit)
            begin
               state_d = SBC_CLEAR; // [RULE3]
               cnt_d = BSOPEN_CYC - 16'h0001;
            end
            else if (wr_hit)
            begin
               mirror_d[wa] = rd; // [RULE13] [RULE15]
               if (wr_otp && (rd != 4'h0))
               begin
                  state_d = SBC_PROG; // [RULE17]
                  cnt_d = 16'(PROG_CYC * 16'(ones4(rd)));
               end
            end
         end
         SBC_PROG:
         begin
            cnt_d = cnt_q - 16'h0001;
            if (cnt_q <= 16'h0001)
            begin
               state_d = SBC_IDLE;
            end
         end
         SBC_CLEAR:
         begin
            cnt_d = cnt_q - 16'h0001;
            if (cnt_q <= 16'h0001)
            begin
               state_d = SBC_IDLE;
               for (int i = 0; i < 16; i++)
               begin
                  mirror_d[i] = 4'h0;
               end
            end
         end
         default:
         begin
            state_d = SBC_IDLE;
         end
      endcase
   end

   // ********************************************************
   // Registers
   // ********************************************************
   // Control state and counters
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_q <= SBC_IDLE;
         cnt_q <= 16'h0000;
         for (int i = 0; i < 16; i++)
         begin
            mirror_q[i] <= 4'h0;
         end
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         mirror_q <= mirror_d;
      end
   end

   // Device address follows its mirror nibble
   assign addr_q = mirror_q[`SBC_ADDR_NIBBLE];

   // Response and strobes; clear never answers
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         resp_valid_q <= 1'b0;
         resp_q <= `SBC_RESP_RST;
         otp_wr_q <= 1'b0;
         otp_a_q <= 4'h0;
         otp_dat_q <= 4'h0;
         bsw_q <= 1'b0;
         lrst_q <= 1'b0;
         busy_q <= 1'b0;
      end
      else
      begin
         resp_valid_q <= wr_hit; // [RULE5]
         if (wr_hit)
         begin
            resp_q <= wr_otp ? resp_otp : resp_mir; // [RULE14] [RULE15]
         end
         otp_wr_q <= wr_otp; // [RULE13]
         otp_a_q <= wr_otp ? wa : otp_a_q;
         otp_dat_q <= wr_otp ? rd : otp_dat_q;
         bsw_q <= clr_hit ? 1'b1 : bsw_q; // [RULE3]
         lrst_q <= clr_hit || (state_q == SBC_CLEAR && state_d == SBC_CLEAR); // [RULE3]
         busy_q <= (state_d != SBC_IDLE); // Registered copy of not-idle
      end
   end

   // Outputs
   assign resp_valid = resp_valid_q;
   assign resp_data = resp_q;
   assign otp_wr = otp_wr_q;
   assign otp_wr_addr = otp_a_q;
   assign otp_wr_data = otp_dat_q;
   assign bus_switch_open = bsw_q;
   assign logic_reset = lrst_q;
   assign busy = busy_q;
   assign assigned_device_address = addr_q;

   // ********************************************************
   // Checks
   // ********************************************************
   AST_CLEAR_OPENS: assert property (@(posedge clk) disable iff (!rst_b) // [RULE3]
      clr_hit |=> bus_switch_open && logic_reset)
      else $error("clear did not open switch");
   AST_CLEAR_SILENT: assert property (@(posedge clk) disable iff (!rst_b) // [RULE5]
      clr_hit |=> !resp_valid)
      else $error("clear produced a response");
   AST_CODE8_IGNORED: assert property (@(posedge clk) disable iff (!rst_b) // [RULE7]
      (frame_valid && cmd_code == `SBC_CMD_UNUSED8) |=> !resp_valid && !otp_wr)
      else $error("code 1000 acted");
   AST_SHORT_WR_IGNORED: assert property (@(posedge clk) disable iff (!rst_b) // [RULE8]
      (frame_valid && cmd_code == `SBC_CMD_WRITE_NVM && !is_long) |=> !resp_valid)
      else $error("short write answered");
   AST_GLOBAL_SELF: assert property (@(posedge clk) disable iff (!rst_b) // [RULE9]
      (frame_valid && addr_q == `SBC_GLOBAL_ADDR && cmd_code == `SBC_CMD_WRITE_NVM)
      |=> !resp_valid)
      else $error("write taken at global address");
   AST_BAD_CRC: assert property (@(posedge clk) disable iff (!rst_b) // [RULE18]
      (frame_valid && !crc_ok && state_q == SBC_IDLE) |=> !resp_valid && !otp_wr
      && (state_q == SBC_IDLE))
      else $error("bad crc frame acted");
   AST_OTP_RESP: assert property (@(posedge clk) disable iff (!rst_b) // [RULE14]
      wr_otp |=> resp_valid && resp_data[7:6] == 2'b11 && otp_wr
      && resp_data[5:4] == $past(bank_select) && resp_data[3:0] == otp_wr_data)
      else $error("otp response wrong");
   AST_MIR_RESP: assert property (@(posedge clk) disable iff (!rst_b) // [RULE15]
      wr_mir |=> resp_valid && resp_data[11:4] == 8'h0f
      && resp_data[15:12] == assigned_device_address && resp_data[3:0] == resp_data[15:12])
      else $error("mirror response wrong");
   AST_ADDR_MATCH: assert property (@(posedge clk) disable iff (!rst_b) // [RULE12]
      (good && cmd_code == `SBC_CMD_WRITE_NVM && cmd_addr != addr_q) |=> !resp_valid)
      else $error("foreign write answered");

endmodule : sbc_cmd
`default_nettype wire

// ---- tb/sbc_master.sv ----
/*
 Bus master model: hands decoded frames to the command handler.
 Assumes the bench calls send and judges the handler's outputs itself.
*/
`timescale 1ns/1ps
`default_nettype none
module sbc_master
   import sbc_pkg::*;
(
   // Clock and pacing
   input wire logic clk,
   input wire logic busy,
   // Frame to the handler
   output logic frame_valid,
   output logic crc_ok,
   output logic [3:0] cmd_code,
   output logic [3:0] cmd_addr,
   output logic [7:0] cmd_data,
   output sbc_fmt_t cmd_fmt
);
   // Idle bus at time zero
   initial
   begin
      {frame_valid, crc_ok, cmd_code, cmd_addr, cmd_data} = '0;
      cmd_fmt = SBC_FMT_STD_LONG;
   end
   // One frame; spacing waits out busy, so programming time is honoured
   task automatic send(input logic [3:0] c, input logic [3:0] a, input logic [7:0] d,
      input sbc_fmt_t f, input logic good, output bit late);
      int n;
      n = 0;
      // One edge first, so back-to-back frames never retoggle valid in one step
      @(negedge clk);
      while (busy !== 1'b0 && n < 1000)
      begin
         @(negedge clk);
         n++;
      end
      late = (n >= 1000);
      {cmd_code, cmd_addr, cmd_data, cmd_fmt, crc_ok} = {c, a, d, f, good};
      frame_valid = 1'b1;
      @(negedge clk);
      frame_valid = 1'b0;
      // Released fields other than cmd_fmt flip, so stale values never pass for live ones
      {cmd_code, cmd_addr, cmd_data, crc_ok} = ~{c, a, d, good};
   endtask : send
endmodule : sbc_master
`default_nettype wire

// ---- tb/tb_top.sv ----
/*
 Self-checking bench for the clear / write-nvm handler.
 Assumes sbc_map.svh on the include path and the master model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sbc_map.svh"
module tb_top;
   import sbc_pkg::*;
   logic clk, rst_b, otp_program_enable, frame_valid, crc_ok, init_addr_load;
   logic [3:0] init_addr;
   logic [1:0] bank_select;
   logic [3:0] cmd_code, cmd_addr, otp_wr_addr, otp_wr_data, assigned_device_address;
   logic [7:0] cmd_data;
   sbc_fmt_t cmd_fmt;
   logic resp_valid, otp_wr, bus_switch_open, logic_reset, busy;
   logic [15:0] resp_data;
   int miscompares, n_tests, n_resp, n_otp;
   // ****************************************
   // Instances
   // ****************************************
   sbc_cmd uut (.clk(clk), .rst_b(rst_b), .frame_valid(frame_valid), .crc_ok(crc_ok),
      .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_fmt(cmd_fmt),
      .otp_program_enable(otp_program_enable), .bank_select(bank_select),
      .init_addr_load(init_addr_load), .init_addr(init_addr),
      .resp_valid(resp_valid), .resp_data(resp_data), .otp_wr(otp_wr),
      .otp_wr_addr(otp_wr_addr), .otp_wr_data(otp_wr_data),
      .bus_switch_open(bus_switch_open), .logic_reset(logic_reset), .busy(busy),
      .assigned_device_address(assigned_device_address));
   sbc_master mst (.clk(clk), .busy(busy), .frame_valid(frame_valid), .crc_ok(crc_ok),
      .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_fmt(cmd_fmt));
   // Clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Pulse counters; sampled mid-cycle so strobes are settled
   always @(negedge clk)
   begin
      if (resp_valid === 1'b1) n_resp++;
      if (otp_wr === 1'b1) n_otp++;
   end
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : give_verdict
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      n_tests++;
      if (g !== e)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic frame(logic [3:0] c, logic [3:0] a, logic [7:0] d, int f, logic good);
      bit late;
      mst.send(c, a, d, sbc_fmt_t'(f[1:0]), good, late);
      chk("pacing", 16'h0, {15'h0, late});
      if (late) give_verdict();
   endtask : frame
   task automatic do_reset();
      rst_b = 1'b0;
      repeat (5) @(negedge clk);
      rst_b = 1'b1;
   endtask : do_reset
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      chk("outs", 16'h0, 16'({bus_switch_open, logic_reset, busy, otp_wr, resp_valid}));
      chk("address", 16'h0, {12'h0, assigned_device_address});
      chk("resp_data", `SBC_RESP_RST, resp_data);
   endtask : t_reset
   // Five kinds of refused frame in every format leave responses, otp writes, switch and busy quiet
   task automatic t_ignored();
      for (int f = 0; f < 4; f++)
      begin
         otp_program_enable = f[0];
         bank_select = f[1:0];
         frame(`SBC_CMD_WRITE_NVM, `SBC_GLOBAL_ADDR, 8'h35, f, 1'b1);
         frame(`SBC_CMD_WRITE_NVM, 4'h5, 8'h3f, f, 1'b1);
         frame(`SBC_CMD_UNUSED8, `SBC_GLOBAL_ADDR, 8'hff, f, 1'b1);
         frame(`SBC_CMD_CLEAR, 4'h5, 8'h00, f, 1'b1);
         frame(`SBC_CMD_CLEAR, `SBC_GLOBAL_ADDR, 8'h00, f, 1'b0);
         repeat (3) @(negedge clk);
         chk("responses", 16'h0, 16'(n_resp));
         chk("otp writes", 16'h0, 16'(n_otp));
         chk("switch, busy", 16'h0, 16'({bus_switch_open, busy}));
      end
   endtask : t_ignored
   // Clear in each format with varied data: switch opens, no answer
   task automatic t_clear();
      int n;
      for (int f = 0; f < 4; f++)
      begin
         do_reset();
         frame(`SBC_CMD_CLEAR, `SBC_GLOBAL_ADDR, 8'h5a ^ 8'(f * 37), f, 1'b1);
         @(negedge clk);
         chk("clear effects", 16'h7, 16'({bus_switch_open, logic_reset, busy}));
         n = 0;
         while (busy === 1'b1 && n < 1000)
         begin
            @(negedge clk);
            n++;
         end
         chk("busy short", 16'h0, 16'(n < `SBC_BSOPEN_CYC - 2));
         chk("busy long", 16'h0, 16'(n > `SBC_BSOPEN_CYC));
         chk("switch held", 16'h1, {15'h0, bus_switch_open});
         chk("no response", 16'h0, 16'(n_resp));
      end
   endtask : t_clear
   // Address load, mirror and otp writes, refusals, then a clear to the own address
   task automatic t_write();
      int n;
      do_reset();
      otp_program_enable = 1'b0;
      bank_select = 2'h2;
      init_addr = 4'h3;
      init_addr_load = 1'b1;
      @(negedge clk);
      init_addr_load = 1'b0;
      chk("loaded address", 16'h3, {12'h0, assigned_device_address});
      frame(`SBC_CMD_WRITE_NVM, 4'h3, 8'h6a, 1, 1'b1);
      chk("short write", 16'h0, {15'h0, resp_valid});
      frame(`SBC_CMD_WRITE_NVM, 4'h3, 8'h6a, 0, 1'b1);
      chk("mirror valid", 16'h1, {15'h0, resp_valid});
      chk("mirror answer", 16'h30f3, resp_data);
      chk("mirror no otp", 16'h0, {15'h0, otp_wr});
      frame(`SBC_CMD_WRITE_NVM, 4'h3, 8'h09, 2, 1'b1);
      chk("new address answer", 16'h90f9, resp_data);
      chk("new address", 16'h9, {12'h0, assigned_device_address});
      frame(`SBC_CMD_WRITE_NVM, 4'h3, 8'h0c, 0, 1'b1);
      chk("old address write", 16'h0, {15'h0, resp_valid});
      frame(`SBC_CMD_WRITE_NVM, `SBC_GLOBAL_ADDR, 8'h0c, 2, 1'b1);
      chk("global write", 16'h0, {15'h0, resp_valid});
      frame(`SBC_CMD_UNUSED8, 4'h9, 8'h9c, 0, 1'b1);
      chk("code 1000 own", 16'h0, {15'h0, resp_valid});
      chk("address kept", 16'h9, {12'h0, assigned_device_address});
      otp_program_enable = 1'b1;
      frame(`SBC_CMD_WRITE_NVM, 4'h9, 8'h5b, 2, 1'b1);
      chk("otp valid", 16'h1, {15'h0, resp_valid});
      chk("otp answer", 16'h95eb, resp_data);
      chk("otp strobe", 16'h015b, {7'h0, otp_wr, otp_wr_addr, otp_wr_data});
      n = 0;
      while (busy === 1'b1 && n < 1000)
      begin
         @(negedge clk);
         n++;
      end
      chk("program time", 16'(3 * `SBC_PROG_BIT_CYC), 16'(n));
      otp_program_enable = 1'b0;
      frame(`SBC_CMD_CLEAR, 4'h9, 8'hc3, 3, 1'b1);
      chk("own clear silent", 16'h0, {15'h0, resp_valid});
      chk("own clear switch", 16'h1, {15'h0, bus_switch_open});
      n = 0;
      while (busy === 1'b1 && n < 1000)
      begin
         @(negedge clk);
         n++;
      end
      chk("cleared address", 16'h0, {12'h0, assigned_device_address});
      chk("otp writes", 16'h1, 16'(n_otp));
   endtask : t_write
   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      {miscompares, n_tests, n_resp, n_otp} = '0;
      otp_program_enable = 1'b0;
      bank_select = 2'h0;
      init_addr_load = 1'b0;
      init_addr = 4'h0;
      do_reset();
      t_reset();
      t_ignored();
      t_clear();
      t_write();
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
